// [common/idq_pkg.sv]
`default_nettype none
package idq_pkg;
    // data and index widths
    localparam int DW = 32;
    localparam int IDX_W = 15;
    localparam int LEN_W = 16;
    localparam int DWORD_SHIFT = 2;
    // shared-memory queue length limits, in dwords
    localparam logic [LEN_W-1:0] QLEN_MIN = 16'h0002;
    localparam logic [LEN_W-1:0] QLEN_MAX = 16'h8000;
    localparam logic [LEN_W-1:0] QLEN_RST = 16'h0002;
    localparam logic [DW-1:0] QPTR_RST = 32'h0000_0000;
    // internal queue, staging fifo and burst sizes
    localparam int IQ_DEPTH = 128;
    localparam int STG_DEPTH = 8;
    localparam int BURST_MAX = 16;
    // channel group geometry
    localparam int NGRP = 8;
    localparam int NCHAN = 32;
    localparam int GRP_W = 3;
    localparam int CHAN_W = 5;
    // status descriptor layout
    localparam int ST_RSVD_BIT = 31;
    localparam int ST_NSI_MSB = 30;
    localparam int ST_NSI_LSB = 16;
    localparam int ST_FULL_BIT = 15;
    localparam int ST_CNT_MSB = 14;
    localparam int ST_CNT_LSB = 0;
    localparam logic [IDX_W-1:0] CNT_SAT = 15'h7fff;
    // bit of an interrupt descriptor flagging that later ones were dropped
    localparam int LOST_BIT = 31;
    // transfer engine states
    typedef enum logic [1:0] {
        IDQ_IDLE,
        IDQ_XFER,
        IDQ_UPD
    } idq_state_e;
endpackage : idq_pkg
`default_nettype wire

// [rtl/idq_rst_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module idq_rst_sync (
    input wire logic clk_sys,
    input wire logic arst_n,
    output logic rst_n
);
    logic meta_ff;
    logic sync_ff;

    // assert at once, release two edges later so no flop sees a ragged release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            sync_ff <= meta_ff;
        end
    end

    assign rst_n = sync_ff;
endmodule : idq_rst_sync
`default_nettype wire

// [rtl/idq_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module idq_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
        $error("idq_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic [AW:0] nxt_cnt;
    logic in_ready_ff;
    logic out_valid_ff;
    logic wr_en;
    logic rd_en;

    // handshakes on both sides
    assign wr_en = in_valid & in_ready_ff;
    assign rd_en = out_valid_ff & out_ready;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (wr_en && !rd_en) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (rd_en && !wr_en) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    // storage, no reset needed: only read behind out_valid
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_ff] <= in_data;
        end
    end

    // pointers and flags; flags are flops so ready never glitches
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            in_ready_ff <= 1'b1;
            out_valid_ff <= 1'b0;
        end else if (flush) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            in_ready_ff <= 1'b1;
            out_valid_ff <= 1'b0;
        end else begin
            wr_ff <= wr_ff + AW'(wr_en);
            rd_ff <= rd_ff + AW'(rd_en);
            cnt_ff <= nxt_cnt;
            in_ready_ff <= (nxt_cnt != (AW + 1)'(DEPTH));
            out_valid_ff <= (nxt_cnt != '0);
        end
    end

    assign in_ready = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data = mem[rd_ff];
endmodule : idq_fifo
`default_nettype wire

// [rtl/idq_ctrl.sv]
// Overview of operation
// - interrupt state restarts on hard reset, soft reset, init, queue-descriptor read or writes.
// - internal queue is ours alone; host owns shared queue, only we write it.
// - any restart clears status descriptor: index zero, not full, count zero.
// - any restart drops every descriptor still held internally, none sent.
// - new pointer or length taken any time, restarting the interrupt logic.
// - group, channel and device masks decide whether a condition becomes a descriptor.
// - internal queue holds up to 128 descriptors awaiting bus mastership.
// - after a transfer burst the status descriptor counts the new entries.
// - interrupt line asserted whenever the pending count is non-zero.
// - writing stops while the shared queue is full until host frees space.
// - queue-full flag set when no further descriptor can be written.
// - both queues full: new descriptors dropped, last queued one marked lost.
// - each status read clears the count, releasing the interrupt line unless a burst update lands in the same cycle.
// - host writes service index to free serviced locations.
// - writing continues into free space whether or not host updated the index.
// - status holds service index, full flag and count since last read.
// - service index is 15 bits at 30:16, read/write, host-updated only.
// - pending count sits at 14:0 and ignores writes.
// - full flag at bit 15, one meaning full, cleared by reading status.
`timescale 1ns/1ps
`default_nettype none
module idq_ctrl #(
    parameter int unsigned IQ_DEPTH = idq_pkg::IQ_DEPTH,
    parameter int unsigned STG_DEPTH = idq_pkg::STG_DEPTH,
    parameter int unsigned BURST = idq_pkg::BURST_MAX
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic soft_chip_rst_req,
    input wire logic global_init_req,
    input wire logic read_qdesc_req,
    input wire logic qptr_wr,
    input wire logic [idq_pkg::DW-1:0] qptr_wr_data,
    input wire logic qlen_wr,
    input wire logic [idq_pkg::LEN_W-1:0] qlen_wr_data,
    input wire logic ev_valid,
    output logic ev_ready,
    input wire logic [idq_pkg::DW-1:0] ev_desc,
    input wire logic [idq_pkg::GRP_W-1:0] ev_group,
    input wire logic [idq_pkg::CHAN_W-1:0] ev_chan,
    input wire logic ev_is_dev,
    input wire logic [idq_pkg::NGRP-1:0] group_mask,
    input wire logic [idq_pkg::NCHAN-1:0] chan_mask,
    input wire logic dev_mask,
    output logic dma_valid,
    input wire logic dma_ready,
    output logic [idq_pkg::DW-1:0] dma_addr,
    output logic [idq_pkg::DW-1:0] dma_data,
    input wire logic stat_rd,
    input wire logic stat_wr,
    input wire logic [idq_pkg::DW-1:0] stat_wr_data,
    output logic [idq_pkg::DW-1:0] stat_rd_data,
    output logic inta_n
);
    import idq_pkg::*;

    localparam int IQ_AW = $clog2(IQ_DEPTH);

    // the ring pointers and burst counter only serve these sizes
    if (IQ_DEPTH < 2 || (IQ_DEPTH & (IQ_DEPTH - 1)) != 0 || BURST < 1 || BURST > 32767) begin : g_chk
        $error("idq_ctrl: IQ_DEPTH must be a power of two >= 2, BURST 1..32767");
    end

    // clamp a host-given length into the addressable range
    function automatic logic [LEN_W-1:0] clamp_len(input logic [LEN_W-1:0] v);
        if (v < QLEN_MIN) begin
            return QLEN_MIN;
        end else if (v > QLEN_MAX) begin
            return QLEN_MAX;
        end
        return v;
    endfunction : clamp_len

    // next dword slot of the circular shared queue
    function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] idx, input logic [LEN_W-1:0] len);
        logic [LEN_W-1:0] inc;
        inc = {1'b0, idx} + 16'h0001;
        if (inc >= len) begin
            return '0;
        end
        return inc[IDX_W-1:0];
    endfunction : next_idx

    // add a burst to the pending count, sticking at the field maximum
    function automatic logic [IDX_W-1:0] sat_add(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] b);
        logic [IDX_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s[IDX_W]) begin
            return CNT_SAT;
        end
        return s[IDX_W-1:0];
    endfunction : sat_add

    logic rst_n;
    logic init;
    logic [DW-1:0] qptr_ff;
    logic [LEN_W-1:0] qlen_ff;
    logic masked;
    logic stg_in_valid;
    logic stg_valid;
    logic stg_ready;
    logic [DW-1:0] stg_data;
    logic [DW-1:0] iq_mem [IQ_DEPTH];
    logic [IQ_AW-1:0] iq_wr_ff;
    logic [IQ_AW-1:0] iq_rd_ff;
    logic [IQ_AW:0] iq_cnt_ff;
    logic [IQ_AW-1:0] last_idx;
    logic iq_full;
    logic iq_empty;
    logic push;
    logic discard;
    logic pop;
    idq_state_e st_ff;
    logic dma_valid_ff;
    logic [DW-1:0] dma_addr_ff;
    logic [DW-1:0] dma_data_ff;
    logic [IDX_W-1:0] widx_ff;
    logic [IDX_W-1:0] widx_adv;
    logic [IDX_W-1:0] burst_ff;
    logic hs;
    logic sh_full;
    logic can_load;
    logic full_set;
    logic [IDX_W-1:0] pending_descriptor_count_ff;
    logic [IDX_W-1:0] nxt_cnt;
    logic queue_full_flag_ff;
    logic nxt_full;
    logic [IDX_W-1:0] host_service_index_ff;
    logic [IDX_W-1:0] nxt_nsi;
    logic [IDX_W-1:0] wr_nsi;
    logic [DW-1:0] stat_rd_data_ff;
    logic inta_n_ff;

    idq_rst_sync u_rst (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .rst_n(rst_n)
    );

    // every path that restarts interrupt handling; hard reset is rst_n itself
    assign init = soft_chip_rst_req | global_init_req | read_qdesc_req | qptr_wr | qlen_wr;

    // queue placement survives soft restarts; only hard reset returns defaults
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qptr_ff <= QPTR_RST;
            qlen_ff <= QLEN_RST;
        end else begin
            if (qptr_wr) begin
                qptr_ff <= {qptr_wr_data[DW-1:DWORD_SHIFT], {DWORD_SHIFT{1'b0}}};
            end
            if (qlen_wr) begin
                qlen_ff <= clamp_len(qlen_wr_data);
            end
        end
    end

    // masked conditions are consumed but never queued
    assign masked = group_mask[ev_group] | chan_mask[ev_chan] | (ev_is_dev & dev_mask);
    assign stg_in_valid = ev_valid & ~masked & ~init;

    // staging fifo decouples the event source from the internal queue
    idq_fifo #(
        .WIDTH(DW),
        .DEPTH(STG_DEPTH)
    ) u_stg (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(init),
        .in_valid(stg_in_valid),
        .in_ready(ev_ready),
        .in_data(ev_desc),
        .out_valid(stg_valid),
        .out_ready(stg_ready),
        .out_data(stg_data)
    );

    assign iq_full = (iq_cnt_ff == (IQ_AW + 1)'(IQ_DEPTH));
    assign iq_empty = (iq_cnt_ff == '0);
    assign last_idx = iq_wr_ff - 1'b1;
    assign push = stg_valid & ~iq_full & ~init;
    // drop only when both queues are stuck; otherwise the source stalls
    assign discard = stg_valid & iq_full & sh_full & ~init;
    assign stg_ready = ~iq_full | sh_full;
    assign hs = dma_valid_ff & dma_ready;
    assign pop = hs & ~init;

    // internal queue storage; a drop marks the newest held descriptor
    always_ff @(posedge clk_sys) begin
        if (push) begin
            iq_mem[iq_wr_ff] <= stg_data;
        end else if (discard) begin
            iq_mem[last_idx][LOST_BIT] <= 1'b1;
        end
    end

    // internal queue pointers; a restart empties it without sending anything
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            iq_wr_ff <= '0;
            iq_rd_ff <= '0;
            iq_cnt_ff <= '0;
        end else if (init) begin
            iq_wr_ff <= '0;
            iq_rd_ff <= '0;
            iq_cnt_ff <= '0;
        end else begin
            iq_wr_ff <= iq_wr_ff + IQ_AW'(push);
            iq_rd_ff <= iq_rd_ff + IQ_AW'(pop);
            iq_cnt_ff <= iq_cnt_ff + (IQ_AW + 1)'(push) - (IQ_AW + 1)'(pop);
        end
    end

    // shared queue occupancy as seen against the host's service index
    assign widx_adv = next_idx(widx_ff, qlen_ff);
    assign sh_full = (widx_adv == host_service_index_ff);
    assign can_load = ~dma_valid_ff & ~iq_empty & ~sh_full & (burst_ff < IDX_W'(BURST));
    assign full_set = (st_ff == IDQ_XFER) & ~dma_valid_ff & ~iq_empty & sh_full;

    // transfer engine: one descriptor per handshake, a status update per burst
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= IDQ_IDLE;
            dma_valid_ff <= 1'b0;
            dma_addr_ff <= '0;
            dma_data_ff <= '0;
            widx_ff <= '0;
            burst_ff <= '0;
        end else if (init) begin
            // an offer in flight is withdrawn; restart begins at the queue base
            st_ff <= IDQ_IDLE;
            dma_valid_ff <= 1'b0;
            widx_ff <= '0;
            burst_ff <= '0;
        end else begin
            case (st_ff)
                IDQ_IDLE: begin
                    burst_ff <= '0;
                    if (!iq_empty) begin
                        st_ff <= IDQ_XFER;
                    end
                end
                IDQ_XFER: begin
                    if (hs) begin
                        dma_valid_ff <= 1'b0;
                        widx_ff <= widx_adv;
                        burst_ff <= burst_ff + 1'b1;
                    end else if (can_load) begin
                        dma_valid_ff <= 1'b1;
                        dma_addr_ff <= qptr_ff + DW'({widx_ff, {DWORD_SHIFT{1'b0}}});
                        dma_data_ff <= iq_mem[iq_rd_ff];
                    end else if (!dma_valid_ff) begin
                        st_ff <= (burst_ff != '0) ? IDQ_UPD : IDQ_IDLE;
                    end
                end
                IDQ_UPD: begin
                    st_ff <= IDQ_IDLE;
                    burst_ff <= '0;
                end
                default: begin
                    st_ff <= IDQ_IDLE;
                end
            endcase
        end
    end

    assign wr_nsi = stat_wr_data[ST_NSI_MSB:ST_NSI_LSB];

    // status descriptor next values; hardware sets win over read clears
    always_comb begin
        nxt_cnt = stat_rd ? '0 : pending_descriptor_count_ff;
        if (st_ff == IDQ_UPD) begin
            nxt_cnt = sat_add(nxt_cnt, burst_ff);
        end
        nxt_full = full_set | (queue_full_flag_ff & ~stat_rd);
        nxt_nsi = stat_wr ? wr_nsi : host_service_index_ff;
        if (init) begin
            nxt_cnt = '0;
            nxt_full = 1'b0;
            nxt_nsi = '0;
        end
    end

    // status fields; count bits ignore writes entirely
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pending_descriptor_count_ff <= '0;
            queue_full_flag_ff <= 1'b0;
            host_service_index_ff <= '0;
        end else begin
            pending_descriptor_count_ff <= nxt_cnt;
            queue_full_flag_ff <= nxt_full;
            host_service_index_ff <= nxt_nsi;
        end
    end

    // read data is the snapshot taken before the read's own clearing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_rd_data_ff <= '0;
        end else if (stat_rd) begin
            stat_rd_data_ff <= '0;
            stat_rd_data_ff[ST_NSI_MSB:ST_NSI_LSB] <= host_service_index_ff;
            stat_rd_data_ff[ST_FULL_BIT] <= queue_full_flag_ff;
            stat_rd_data_ff[ST_CNT_MSB:ST_CNT_LSB] <= pending_descriptor_count_ff;
        end
    end

    // interrupt line tracks the count in the same cycle it changes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            inta_n_ff <= 1'b1;
        end else begin
            inta_n_ff <= (nxt_cnt == '0);
        end
    end

    assign dma_valid = dma_valid_ff;
    assign dma_addr = dma_addr_ff;
    assign dma_data = dma_data_ff;
    assign stat_rd_data = stat_rd_data_ff;
    assign inta_n = inta_n_ff;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_hs;
        dma_valid_ff && dma_ready && !init;
    endsequence

    sequence s_load;
        !dma_valid_ff ##1 dma_valid_ff;
    endsequence

    init_clear_a: assert property (init |=> (pending_descriptor_count_ff == '0) && !queue_full_flag_ff)
        else $error("status not cleared after restart");

    init_drop_a: assert property (init |=> (iq_cnt_ff == '0) && !dma_valid_ff)
        else $error("internal queue kept descriptors across restart");

    iq_cap_a: assert property (iq_cnt_ff <= (IQ_AW + 1)'(IQ_DEPTH))
        else $error("internal queue overfilled");

    load_guard_a: assert property (s_load |-> !$past(sh_full))
        else $error("descriptor offered while shared queue full");

    write_wrap_a: assert property (s_hs |=> widx_ff == $past(widx_adv))
        else $error("write index did not step or wrap");

    burst_count_a: assert property ((st_ff == IDQ_UPD) && !init |=>
        (pending_descriptor_count_ff != '0) && !inta_n_ff)
        else $error("burst not reflected in pending count");

    inta_level_a: assert property (inta_n_ff == (pending_descriptor_count_ff == '0))
        else $error("interrupt line disagrees with pending count");

    read_clear_a: assert property (stat_rd && (st_ff != IDQ_UPD) && !init ##1 1 |-> inta_n_ff)
        else $error("status read did not clear count");

    // a restart one cycle after the set legally clears the flag again
    full_flag_a: assert property (full_set && !init |=> queue_full_flag_ff ##1
        (queue_full_flag_ff || $past(stat_rd) || $past(init)))
        else $error("queue full flag not set or lost early");

    full_clear_a: assert property (stat_rd && !full_set && !init |=> !queue_full_flag_ff)
        else $error("full flag survived a status read");

    nsi_write_a: assert property (stat_wr && !init |=> host_service_index_ff == $past(wr_nsi))
        else $error("service index write not taken");

    lost_mark_a: assert property (discard |=> iq_mem[$past(last_idx)][LOST_BIT])
        else $error("dropped descriptor not marked");
endmodule : idq_ctrl
`default_nettype wire

// [tb/idq_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host memory side: takes queue writes, can starve the engine
module idq_host_model (
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic dma_valid,
    output logic dma_ready,
    input wire logic [idq_pkg::DW-1:0] dma_addr,
    input wire logic [idq_pkg::DW-1:0] dma_data
);
    logic [idq_pkg::DW-1:0] mem [int];
    int n_wr = 0;
    int seed = 32'h7441;
    initial dma_ready = 1'b0;
    // ready moves off the sampling edge; slow mode grants about one cycle in four
    always @(negedge clk_sys) begin
        dma_ready <= slow ? ($random(seed) % 4 == 0) : 1'b1;
    end
    // only the device fills the shared queue; host just keeps what lands
    always @(posedge clk_sys) begin
        if (dma_valid && dma_ready) begin
            mem[int'(dma_addr[31:2])] = dma_data;
            n_wr++;
        end
    end
endmodule : idq_host_model
`default_nettype wire

// [tb/idq_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin n_errors++; $display("FAIL %0t %s", $time, m); end end
module idq_ctrl_tb_top;
    import idq_pkg::*;
    localparam logic [DW-1:0] BASE = 32'h0000_1000;
    logic clk_sys = 1'b0, arst_n = 1'b0, soft_chip_rst_req = 1'b0, global_init_req = 1'b0;
    logic read_qdesc_req = 1'b0, qptr_wr = 1'b0, qlen_wr = 1'b0, ev_valid = 1'b0, ev_is_dev = 1'b0;
    logic dev_mask = 1'b0, stat_rd = 1'b0, stat_wr = 1'b0, slow = 1'b0;
    logic [DW-1:0] qptr_wr_data = BASE, ev_desc = '0, stat_wr_data = '0;
    logic [LEN_W-1:0] qlen_wr_data = 16'h0040;
    logic [GRP_W-1:0] ev_group = '0;
    logic [CHAN_W-1:0] ev_chan = '0;
    logic [NGRP-1:0] group_mask = '0;
    logic [NCHAN-1:0] chan_mask = '0;
    logic ev_ready, dma_valid, dma_ready, inta_n;
    logic [DW-1:0] dma_addr, dma_data, stat_rd_data;
    logic [DW-1:0] sent [$];
    int n_errors = 0, compares = 0, cyc = 0, seed = 32'h7440, done_wr = 0, wi = 0, ql = 64;

    always #2.5 clk_sys = ~clk_sys;

    idq_ctrl dut_u (.clk_sys, .arst_n, .soft_chip_rst_req, .global_init_req, .read_qdesc_req,
        .qptr_wr, .qptr_wr_data, .qlen_wr, .qlen_wr_data, .ev_valid, .ev_ready, .ev_desc,
        .ev_group, .ev_chan, .ev_is_dev, .group_mask, .chan_mask, .dev_mask, .dma_valid,
        .dma_ready, .dma_addr, .dma_data, .stat_rd, .stat_wr, .stat_wr_data, .stat_rd_data, .inta_n);
    idq_host_model host_u (.clk_sys, .slow, .dma_valid, .dma_ready, .dma_addr, .dma_data);

    // expected status word; reserved bit always reads zero
    function automatic logic [DW-1:0] exp_stat(input int idx, input logic full, input int cnt);
        exp_stat = {1'b0, IDX_W'(idx), full, IDX_W'(cnt)};
    endfunction : exp_stat

    function automatic logic unmasked(input logic [GRP_W-1:0] g, input logic [CHAN_W-1:0] c, input logic d);
        unmasked = !(group_mask[g] || chan_mask[c] || (d && dev_mask));
    endfunction : unmasked

    task automatic tick(input int n = 1);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    // one-cycle strobe launched off the sampling edge, then a quiet cycle
    // so a repeated strobe never rises in the step that lowered it
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
    endtask : pulse

    // offer one random condition; valid stays up so offers run back to back
    task automatic send();
        int k;
        k = 0;
        ev_desc = $random(seed);
        ev_desc[LOST_BIT] = 1'b0;
        ev_group = GRP_W'($random(seed));
        ev_chan = CHAN_W'($random(seed));
        ev_is_dev = 1'($random(seed));
        ev_valid = 1'b1;
        while (ev_ready !== 1'b1 && k < 500) begin
            tick();
            k++;
        end
        if (k >= 500) begin
            n_errors++;
            $display("FAIL %0t ready stuck low", $time);
        end
        if (unmasked(ev_group, ev_chan, ev_is_dev)) sent.push_back(ev_desc);
        tick();
    endtask : send

    // wait for n more queue writes, then check no stray write and each slot
    task automatic drain(input int n);
        int k;
        k = 0;
        done_wr += n;
        while (host_u.n_wr < done_wr && k < 5000) begin
            tick();
            k++;
        end
        tick(30);
        `CHK(host_u.n_wr, done_wr, "write count")
        repeat (n) begin
            `CHK(host_u.mem[int'(BASE[DW-1:2]) + wi], sent.pop_front(), "queue slot")
            wi = (wi + 1) % ql;
        end
    endtask : drain

    // status read as the host does it, with the line checked either side
    task automatic chk_stat(input int idx, input logic full, input int cnt);
        `CHK(inta_n, logic'(cnt == 0), "irq level")
        pulse(stat_rd);
        `CHK(stat_rd_data, exp_stat(idx, full, cnt), "status word")
        `CHK(inta_n, 1'b1, "irq release")
    endtask : chk_stat

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // the run needs about a thousand cycles; far beyond that is a hang
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            $display("FAIL %0t timeout", $time);
            conclude();
        end
    end

    // main sequence
    initial begin
        tick(3);
        arst_n = 1'b1;
        tick(3);
        `CHK(stat_rd_data, 32'h0000_0000, "reset status")
        `CHK(dma_valid, 1'b0, "reset dma")
        `CHK(ev_ready, 1'b1, "reset ready")
        pulse(qptr_wr);
        pulse(qlen_wr);
        $display("test reset done");
        // random masks against random conditions
        repeat (20) begin
            group_mask = NGRP'($random(seed) & $random(seed));
            chan_mask = $random(seed) & $random(seed);
            dev_mask = 1'($random(seed));
            send();
        end
        ev_valid = 1'b0;
        group_mask = '0;
        chan_mask = '0;
        dev_mask = 1'b0;
        drain(sent.size());
        chk_stat(0, 1'b0, done_wr);
        $display("test masks done");
        // four-dword queue: three slots usable, the rest wait inside
        qlen_wr_data = 16'h0004;
        ql = 4;
        pulse(qlen_wr);
        wi = 0;
        slow = 1'b1;
        repeat (5) send();
        ev_valid = 1'b0;
        drain(3);
        chk_stat(0, 1'b1, 3);
        stat_wr_data = 32'h8003_ffff;
        pulse(stat_wr);
        drain(2);
        chk_stat(3, 1'b1, 2);
        chk_stat(3, 1'b0, 0);
        $display("test wrap done");
        // each soft restart trigger drops held descriptors and zeroes the status
        for (int k = 0; k < 5; k++) begin
            pulse(qlen_wr);
            wi = 0;
            slow = 1'($random(seed));
            repeat (5) send();
            ev_valid = 1'b0;
            drain(3);
            case (k)
                0: pulse(soft_chip_rst_req);
                1: pulse(global_init_req);
                2: pulse(read_qdesc_req);
                3: pulse(qptr_wr);
                default: pulse(qlen_wr);
            endcase
            sent.delete();
            drain(0);
            chk_stat(0, 1'b0, 0);
        end
        $display("test restart done");
        // both queues full: extra conditions dropped, last kept one marked
        qlen_wr_data = 16'h0100;
        ql = 256;
        pulse(qlen_wr);
        wi = 0;
        slow = 1'b0;
        stat_wr_data = 32'h0008_0000;
        pulse(stat_wr);
        repeat (7 + IQ_DEPTH + 4) send();
        ev_valid = 1'b0;
        repeat (4) void'(sent.pop_back());
        sent[$][LOST_BIT] = 1'b1;
        drain(7);
        chk_stat(8, 1'b1, 7);
        stat_wr_data = 32'h0000_0000;
        pulse(stat_wr);
        drain(IQ_DEPTH);
        chk_stat(0, 1'b1, IQ_DEPTH);
        $display("test lost done");
        conclude();
    end
endmodule : idq_ctrl_tb_top
`default_nettype wire
